/* File: hdl/exposure_trigger_sequencer_pkg.sv */
// shared constants and types for the exposure trigger sequencer
package exposure_trigger_sequencer_pkg;

  // ------------------------------------------------------------------
  // register map
  // ------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_CMD      = 8'h04;
  localparam logic [7:0] ADDR_EXPOSURE = 8'h08;
  localparam logic [7:0] ADDR_LINE_LEN = 8'h0C;
  localparam logic [7:0] ADDR_LINE_GAP = 8'h10;
  localparam logic [7:0] ADDR_LINES    = 8'h14;
  localparam logic [7:0] ADDR_FRAME_GAP = 8'h18;
  localparam logic [7:0] ADDR_OFFSET   = 8'h1C;
  localparam logic [7:0] ADDR_STATUS   = 8'h20;

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int CTRL_MODE_LSB   = 0;
  localparam int CTRL_STROBE_EN  = 3;
  localparam int CTRL_STROBE_GPO = 4;
  localparam int CTRL_GPO_LEVEL  = 5;
  localparam int CMD_ARM         = 0;
  localparam int CMD_DISABLE     = 1;

  // ------------------------------------------------------------------
  // reset values, synchroniser depth and trigger input count
  // ------------------------------------------------------------------
  localparam logic [31:0] RST_EXPOSURE  = 32'h0000_0064;
  localparam logic [15:0] RST_LINE_LEN  = 16'h0010;
  localparam logic [15:0] RST_LINE_GAP  = 16'h0004;
  localparam logic [15:0] RST_LINES     = 16'h0008;
  localparam logic [15:0] RST_FRAME_GAP = 16'h0008;
  localparam logic [7:0]  RST_OFFSET    = 8'h00;
  localparam int          SYNC_STAGES   = 3;
  localparam int          TRIG_INPUTS   = 2;

  // ------------------------------------------------------------------
  // types
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_OVL_SHUTTER,
    MODE_OVL_EXTENDED,
    MODE_NON_OVERLAP,
    MODE_SINGLE,
    MODE_BULB
  } mode_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ARMED,
    ST_EXPOSE,
    ST_READ,
    ST_OVERLAP
  } state_t;

  typedef struct packed {
    logic [2:0] mode;
    logic       strobe_en;
    logic       strobe_gpo;
    logic       gpo_level;
  } ctrl_t;

  typedef struct packed {
    logic [15:0] line_len;
    logic [15:0] line_gap;
    logic [15:0] lines;
    logic [15:0] frame_gap;
  } timing_t;

endpackage : exposure_trigger_sequencer_pkg

/* File: hdl/exposure_trigger_sequencer.sv */
// exposure and readout sequencer with trigger, strobe and video timing
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - shuttered overlap mode waits armed for trigger fall, exposes, then overlaps
// - shutter sets exposure from software count; frame period stays readout time
// - continuous modes ignore further trigger edges until stopped
// - continuous run lasts until host disables; host may then re-arm
// - extended overlap: no shutter, frame period is the longer of exposure length and readout time
// - extended overlap keeps strobe low regardless of strobe enable
// - non-overlap mode alternates exposure and readout, never together
// - single mode: one exposure and readout per trigger, then armed again
// - single mode exposure length comes from the software exposure count
// - bulb exposes from trigger leading edge to trailing edge
// - bulb readout starts right after trailing edge, then back to armed
// - bulb ignores all trigger activity during readout
// - enabled strobe is high during exposure in supported modes, else low
// - strobe may be a general output whose level the host sets
// - line valid is high on valid pixels, low in line and frame gaps
// - frame valid stays high over all active lines, low between frames
// - trigger echo is an active-low buffered copy of the host trigger
// - auxiliary trigger acts like the host trigger, but is not copied to the trigger echo
// - black offset setting has 256 steps
module exposure_trigger_sequencer (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  input  wire logic        i_cc1_trig_n,
  input  wire logic        i_aux_trig_n,
  output logic             o_trigger_echo_out_n,
  output logic             o_line_valid_out,
  output logic             o_frame_valid_out,
  output logic             o_strobe,
  output logic      [7:0]  o_black_offset
);

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  exposure_trigger_sequencer_pkg::ctrl_t   ctrl_q;
  exposure_trigger_sequencer_pkg::timing_t tim_q;
  exposure_trigger_sequencer_pkg::state_t  state_q;
  logic [31:0] exposure_q;
  logic [7:0]  offset_q;
  logic        cmd_arm;
  logic        cmd_disable;
  logic        mode_ovl;
  logic        mode_ext;
  logic        mode_non;
  logic        mode_single;
  logic        mode_bulb;

  assign cmd_arm     = i_wr && (i_addr == exposure_trigger_sequencer_pkg::ADDR_CMD)
                       && i_wdata[exposure_trigger_sequencer_pkg::CMD_ARM];
  assign cmd_disable = i_wr && (i_addr == exposure_trigger_sequencer_pkg::ADDR_CMD)
                       && i_wdata[exposure_trigger_sequencer_pkg::CMD_DISABLE];

  assign mode_ovl    = ctrl_q.mode == exposure_trigger_sequencer_pkg::MODE_OVL_SHUTTER;
  assign mode_ext    = ctrl_q.mode == exposure_trigger_sequencer_pkg::MODE_OVL_EXTENDED;
  assign mode_non    = ctrl_q.mode == exposure_trigger_sequencer_pkg::MODE_NON_OVERLAP;
  assign mode_single = ctrl_q.mode == exposure_trigger_sequencer_pkg::MODE_SINGLE;
  assign mode_bulb   = ctrl_q.mode == exposure_trigger_sequencer_pkg::MODE_BULB;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ctrl_q          <= '0;
      exposure_q      <= exposure_trigger_sequencer_pkg::RST_EXPOSURE;
      tim_q.line_len  <= exposure_trigger_sequencer_pkg::RST_LINE_LEN;
      tim_q.line_gap  <= exposure_trigger_sequencer_pkg::RST_LINE_GAP;
      tim_q.lines     <= exposure_trigger_sequencer_pkg::RST_LINES;
      tim_q.frame_gap <= exposure_trigger_sequencer_pkg::RST_FRAME_GAP;
      offset_q        <= exposure_trigger_sequencer_pkg::RST_OFFSET;
    end else if (i_wr) begin
      case (i_addr)
        exposure_trigger_sequencer_pkg::ADDR_CTRL: begin
          ctrl_q.mode       <= i_wdata[2:0];
          ctrl_q.strobe_en  <= i_wdata[exposure_trigger_sequencer_pkg::CTRL_STROBE_EN];
          ctrl_q.strobe_gpo <= i_wdata[exposure_trigger_sequencer_pkg::CTRL_STROBE_GPO];
          ctrl_q.gpo_level  <= i_wdata[exposure_trigger_sequencer_pkg::CTRL_GPO_LEVEL];
        end
        exposure_trigger_sequencer_pkg::ADDR_EXPOSURE:  exposure_q      <= i_wdata;
        exposure_trigger_sequencer_pkg::ADDR_LINE_LEN:  tim_q.line_len  <= i_wdata[15:0];
        exposure_trigger_sequencer_pkg::ADDR_LINE_GAP:  tim_q.line_gap  <= i_wdata[15:0];
        exposure_trigger_sequencer_pkg::ADDR_LINES:     tim_q.lines     <= i_wdata[15:0];
        exposure_trigger_sequencer_pkg::ADDR_FRAME_GAP: tim_q.frame_gap <= i_wdata[15:0];
        exposure_trigger_sequencer_pkg::ADDR_OFFSET:    offset_q        <= i_wdata[7:0];
        default: ;
      endcase
    end
  end

  assign o_black_offset = offset_q;

  // ------------------------------------------------------------------
  // trigger synchronisers
  // ------------------------------------------------------------------
  localparam int TRIG_W = exposure_trigger_sequencer_pkg::TRIG_INPUTS;
  logic [TRIG_W-1:0] trig_raw;
  logic [TRIG_W-1:0] trig_lvl_q;
  logic              trig_n;
  logic              trig_prev_q;
  logic              trig_fall;
  logic              trig_rise;

  assign trig_raw = {i_aux_trig_n, i_cc1_trig_n};
  generate
    for (genvar g = 0; g < TRIG_W; g = g + 1) begin : g_sync
      logic [exposure_trigger_sequencer_pkg::SYNC_STAGES-1:0] sync_q;
      always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
          sync_q        <= '1;
          trig_lvl_q[g] <= 1'b1;
        end else begin
          sync_q <= {sync_q[1:0], trig_raw[g]};
          if (sync_q[1] == sync_q[2]) begin
            trig_lvl_q[g] <= sync_q[2];
          end
        end
      end
    end
  endgenerate

  // either input asserts the trigger
  assign trig_n    = &trig_lvl_q;
  assign trig_fall = trig_prev_q && !trig_n;
  assign trig_rise = !trig_prev_q && trig_n;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      trig_prev_q          <= 1'b1;
      o_trigger_echo_out_n <= 1'b1;
    end else begin
      trig_prev_q          <= trig_n;
      o_trigger_echo_out_n <= trig_lvl_q[0];
    end
  end

  // ------------------------------------------------------------------
  // readout engine
  // ------------------------------------------------------------------
  logic [31:0] frame_total;
  logic [31:0] line_period;
  logic [31:0] rd_left_q;
  logic [15:0] pix_q;
  logic [15:0] line_q;
  logic        rd_busy_q;
  logic        rd_start;
  logic        rd_done;
  logic        fv;

  assign line_period = 32'(tim_q.line_len) + 32'(tim_q.line_gap);
  assign frame_total = 32'(tim_q.lines) * line_period
                       + 32'(tim_q.frame_gap);
  assign rd_done     = rd_busy_q && (rd_left_q == 32'h0000_0001);

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rd_busy_q <= 1'b0;
      rd_left_q <= '0;
      pix_q     <= '0;
      line_q    <= '0;
    end else if (rd_start) begin
      rd_busy_q <= 1'b1;
      rd_left_q <= frame_total;
      pix_q     <= '0;
      line_q    <= '0;
    end else if (rd_busy_q) begin
      rd_left_q <= rd_left_q - 32'h0000_0001;
      if (rd_done) begin
        rd_busy_q <= 1'b0;
      end
      if (32'(pix_q) == line_period - 32'h0000_0001) begin
        pix_q  <= '0;
        line_q <= line_q + 16'h0001;
      end else begin
        pix_q <= pix_q + 16'h0001;
      end
    end
  end

  assign fv = rd_busy_q && (line_q < tim_q.lines);

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_frame_valid_out <= 1'b0;
      o_line_valid_out  <= 1'b0;
    end else begin
      o_frame_valid_out <= fv;
      o_line_valid_out  <= fv && (pix_q < tim_q.line_len);
    end
  end

  // ------------------------------------------------------------------
  // exposure state machine
  // ------------------------------------------------------------------
  logic [31:0] exp_q;
  logic        exp_end;
  logic        exposing;

  assign exp_end = exp_q <= 32'h0000_0001;

  always_comb begin
    rd_start = 1'b0;
    case (state_q)
      exposure_trigger_sequencer_pkg::ST_EXPOSE: begin
        rd_start = mode_bulb ? trig_rise : exp_end;
      end
      exposure_trigger_sequencer_pkg::ST_OVERLAP: begin
        if (mode_ovl) begin
          rd_start = rd_done;
        end else begin
          rd_start = exp_end && !rd_busy_q;
        end
      end
      default: rd_start = 1'b0;
    endcase
    if (cmd_disable) begin
      rd_start = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_q <= exposure_trigger_sequencer_pkg::ST_IDLE;
      exp_q   <= '0;
    end else if (cmd_disable) begin
      state_q <= exposure_trigger_sequencer_pkg::ST_IDLE;
    end else begin
      case (state_q)
        exposure_trigger_sequencer_pkg::ST_IDLE: begin
          if (cmd_arm) begin
            state_q <= exposure_trigger_sequencer_pkg::ST_ARMED;
          end
        end
        exposure_trigger_sequencer_pkg::ST_ARMED: begin
          if (trig_fall) begin
            state_q <= exposure_trigger_sequencer_pkg::ST_EXPOSE;
            exp_q   <= exposure_q;
          end
        end
        exposure_trigger_sequencer_pkg::ST_EXPOSE: begin
          if (mode_bulb) begin
            if (trig_rise) begin
              state_q <= exposure_trigger_sequencer_pkg::ST_READ;
            end
          end else if (exp_end) begin
            exp_q <= exposure_q;
            if (mode_ovl || mode_ext) begin
              state_q <= exposure_trigger_sequencer_pkg::ST_OVERLAP;
            end else begin
              state_q <= exposure_trigger_sequencer_pkg::ST_READ;
            end
          end else begin
            exp_q <= exp_q - 32'h0000_0001;
          end
        end
        exposure_trigger_sequencer_pkg::ST_READ: begin
          // trigger edges are not looked at while reading out
          if (rd_done) begin
            if (mode_non) begin
              state_q <= exposure_trigger_sequencer_pkg::ST_EXPOSE;
              exp_q   <= exposure_q;
            end else begin
              state_q <= exposure_trigger_sequencer_pkg::ST_ARMED;
            end
          end
        end
        exposure_trigger_sequencer_pkg::ST_OVERLAP: begin
          // free running: triggers ignored until disabled
          if (mode_ext) begin
            if (rd_start) begin
              exp_q <= exposure_q;
            end else if (!exp_end) begin
              exp_q <= exp_q - 32'h0000_0001;
            end
          end
        end
        default: state_q <= exposure_trigger_sequencer_pkg::ST_IDLE;
      endcase
    end
  end

  // shuttered overlap exposes during the tail of each frame
  always_comb begin
    exposing = 1'b0;
    case (state_q)
      exposure_trigger_sequencer_pkg::ST_EXPOSE:  exposing = 1'b1;
      exposure_trigger_sequencer_pkg::ST_OVERLAP: begin
        exposing = mode_ext
                   || (rd_busy_q && (rd_left_q <= exposure_q));
      end
      default: exposing = 1'b0;
    endcase
  end

  // ------------------------------------------------------------------
  // strobe output
  // ------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_strobe <= 1'b0;
    end else if (ctrl_q.strobe_gpo) begin
      o_strobe <= ctrl_q.gpo_level;
    end else begin
      o_strobe <= ctrl_q.strobe_en && exposing && !mode_ext
                  && !cmd_disable;
    end
  end

  // ------------------------------------------------------------------
  // register read port
  // ------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_rdata <= '0;
    end else if (i_rd) begin
      case (i_addr)
        exposure_trigger_sequencer_pkg::ADDR_CTRL:
          o_rdata <= {26'h000_0000, ctrl_q.gpo_level, ctrl_q.strobe_gpo,
                      ctrl_q.strobe_en, ctrl_q.mode};
        exposure_trigger_sequencer_pkg::ADDR_EXPOSURE:
          o_rdata <= exposure_q;
        exposure_trigger_sequencer_pkg::ADDR_LINE_LEN:
          o_rdata <= {16'h0000, tim_q.line_len};
        exposure_trigger_sequencer_pkg::ADDR_LINE_GAP:
          o_rdata <= {16'h0000, tim_q.line_gap};
        exposure_trigger_sequencer_pkg::ADDR_LINES:
          o_rdata <= {16'h0000, tim_q.lines};
        exposure_trigger_sequencer_pkg::ADDR_FRAME_GAP:
          o_rdata <= {16'h0000, tim_q.frame_gap};
        exposure_trigger_sequencer_pkg::ADDR_OFFSET:
          o_rdata <= {24'h00_0000, offset_q};
        exposure_trigger_sequencer_pkg::ADDR_STATUS:
          o_rdata <= {25'h000_0000, trig_n, fv, exposing, rd_busy_q,
                      state_q};
        default: o_rdata <= '0;
      endcase
    end else begin
      o_rdata <= '0;
    end
  end

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  arm_to_expose_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (state_q == exposure_trigger_sequencer_pkg::ST_ARMED && trig_fall
     && !cmd_disable) |=> state_q == exposure_trigger_sequencer_pkg::ST_EXPOSE)
    else $error("trigger fall did not start exposure");
  shutter_frame_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (state_q == exposure_trigger_sequencer_pkg::ST_OVERLAP && mode_ovl
     && rd_busy_q && !rd_done) |-> !rd_start)
    else $error("shuttered frame restarted early");
  run_holds_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (state_q == exposure_trigger_sequencer_pkg::ST_OVERLAP && !cmd_disable)
    |=> state_q == exposure_trigger_sequencer_pkg::ST_OVERLAP)
    else $error("continuous run left without disable");
  disable_idle_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    cmd_disable |=> state_q == exposure_trigger_sequencer_pkg::ST_IDLE
                    && !rd_start && (!o_strobe || ctrl_q.strobe_gpo))
    else $error("disable not honoured");
  ext_strobe_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (mode_ext && !ctrl_q.strobe_gpo) ##1 (mode_ext && !ctrl_q.strobe_gpo)
    |-> !o_strobe)
    else $error("strobe active in extended mode");
  single_rearm_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (state_q == exposure_trigger_sequencer_pkg::ST_READ && rd_done
     && mode_single && !cmd_disable)
    |=> state_q == exposure_trigger_sequencer_pkg::ST_ARMED)
    else $error("single frame did not re-arm");
  bulb_readout_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (state_q == exposure_trigger_sequencer_pkg::ST_EXPOSE && mode_bulb
     && trig_rise && !cmd_disable)
    |=> state_q == exposure_trigger_sequencer_pkg::ST_READ && rd_busy_q)
    else $error("bulb readout did not start");
  bulb_ignore_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (state_q == exposure_trigger_sequencer_pkg::ST_READ && !rd_done
     && !cmd_disable) |=> state_q == exposure_trigger_sequencer_pkg::ST_READ)
    else $error("readout disturbed by trigger");
  strobe_off_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (!ctrl_q.strobe_en && !ctrl_q.strobe_gpo) |=> !o_strobe || $past(i_wr))
    else $error("strobe high while disabled");
  gpo_level_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    ctrl_q.strobe_gpo |=> o_strobe == $past(ctrl_q.gpo_level))
    else $error("general output level wrong");
  line_in_frame_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_line_valid_out |-> o_frame_valid_out)
    else $error("line valid outside frame");
  echo_copy_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    ##1 o_trigger_echo_out_n == $past(trig_lvl_q[0]))
    else $error("trigger echo does not follow host trigger");
endmodule : exposure_trigger_sequencer
`default_nettype wire

/* File: tb/host_frame_grabber.sv */
// host side model that drives the two trigger pins
`timescale 1ns/1ps
`default_nettype none
module host_frame_grabber (
  input  wire logic i_clk,
  output logic      o_cc1_trig_n,
  output logic      o_aux_trig_n
);
  initial begin
    o_cc1_trig_n = 1'b1;
    o_aux_trig_n = 1'b1;
  end
  // low pulse of w cycles, then both pins released high
  task automatic pulse(input bit aux, input int w);
    @(posedge i_clk);
    if (aux) begin
      o_aux_trig_n <= 1'b0;
    end else begin
      o_cc1_trig_n <= 1'b0;
    end
    repeat (w) @(posedge i_clk);
    o_aux_trig_n <= 1'b1;
    o_cc1_trig_n <= 1'b1;
  endtask : pulse
endmodule : host_frame_grabber
`default_nettype wire

/* File: tb/exposure_trigger_sequencer_test.sv */
// self-checking bench for the exposure trigger sequencer
`timescale 1ns/1ps
`default_nettype none
module exposure_trigger_sequencer_test;
  logic        i_clk = 1'b0, i_rst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
  logic [7:0]  i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0000_0000;
  logic [31:0] o_rdata, rv;
  logic        o_echo_n, o_lv, o_fv, o_strobe, fv_q;
  logic [7:0]  o_off;
  wire logic   cc1_n, aux_n;
  int bad_count = 0, n_checks = 0, seed = 47;
  int n_st, n_lv, n_fr, n_ov, e, w, st0, fr0, ov0;
  always #12.5 i_clk = ~i_clk;
  host_frame_grabber u_host (.i_clk(i_clk), .o_cc1_trig_n(cc1_n),
    .o_aux_trig_n(aux_n));
  exposure_trigger_sequencer DUT (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_cc1_trig_n(cc1_n), .i_aux_trig_n(aux_n),
    .o_trigger_echo_out_n(o_echo_n), .o_line_valid_out(o_lv),
    .o_frame_valid_out(o_fv), .o_strobe(o_strobe),
    .o_black_offset(o_off));
  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, exp, input string m);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask : rd
  function automatic logic [31:0] cw(input int m, input bit en, g, l);
    cw = 32'(m);
    cw[exposure_trigger_sequencer_pkg::CTRL_STROBE_EN] = en;
    cw[exposure_trigger_sequencer_pkg::CTRL_STROBE_GPO] = g;
    cw[exposure_trigger_sequencer_pkg::CTRL_GPO_LEVEL] = l;
  endfunction : cw
  task automatic clr;
    #1 n_st = 0;
    n_lv = 0;
    n_fr = 0;
    n_ov = 0;
  endtask : clr
  task automatic wait_st(input logic [2:0] s);
    for (int i = 0; i < 200; i++) begin
      rd(exposure_trigger_sequencer_pkg::ADDR_STATUS, rv);
      if (rv[2:0] === s) break;
      repeat (8) @(posedge i_clk);
    end
    chk(rv[2:0], s, "state");
  endtask : wait_st
  task automatic arm(input int m, input bit en, input int x);
    wr(exposure_trigger_sequencer_pkg::ADDR_CTRL, cw(m, en, 0, 0));
    wr(exposure_trigger_sequencer_pkg::ADDR_EXPOSURE, 32'(x));
    wr(exposure_trigger_sequencer_pkg::ADDR_CMD, 32'h0000_0001);
    clr();
  endtask : arm
  // one triggered frame; optional extra trigger during readout
  task automatic one(input int m, input bit en, aux, input int pw, bit ag);
    arm(m, en, e);
    u_host.pulse(aux, pw);
    repeat (20) @(posedge i_clk);
    if (ag) u_host.pulse(0, 5);
    wait_st(exposure_trigger_sequencer_pkg::ST_ARMED);
    chk(n_fr, 1, "one frame per trigger");
    chk(n_lv, 128, "line valid cycles");
  endtask : one
  // free run, late trigger, then disable
  task automatic cont(input int m, input int x);
    arm(m, 1, x);
    u_host.pulse(0, 4);
    repeat (700) @(posedge i_clk);
    u_host.pulse(1, 4);
    st0 = n_st;
    fr0 = n_fr;
    ov0 = n_ov;
    rd(exposure_trigger_sequencer_pkg::ADDR_STATUS, rv);
    chk(rv[2:0] > 3'd1, 1, "still running");
    wr(exposure_trigger_sequencer_pkg::ADDR_CMD, 32'h0000_0002);
    wait_st(exposure_trigger_sequencer_pkg::ST_IDLE);
    clr();
    repeat (300) @(posedge i_clk);
    chk(n_fr, 0, "stopped");
  endtask : cont
  always @(posedge i_clk) begin
    fv_q <= o_fv;
    if (o_strobe === 1'b1) n_st++;
    if (o_lv === 1'b1) n_lv++;
    if (o_fv === 1'b1 && fv_q !== 1'b1) n_fr++;
    if (o_strobe === 1'b1 && o_fv === 1'b1) n_ov++;
    if (o_lv === 1'b1) chk(o_fv, 1, "lv outside fv");
  end
  initial begin
    repeat (30000) @(posedge i_clk);
    bad_count++;
    summarize();
  end
  // ------------------------------------------------------------------
  // tests
  // ------------------------------------------------------------------
  initial begin
    repeat (16) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rd(exposure_trigger_sequencer_pkg::ADDR_EXPOSURE, rv);
    chk(rv, exposure_trigger_sequencer_pkg::RST_EXPOSURE, "exp rst");
    rd(exposure_trigger_sequencer_pkg::ADDR_CMD, rv);
    chk(rv, 0, "cmd reads zero");
    rd(8'hFC, rv);
    chk(rv, 0, "unmapped read");
    w = $random(seed);
    wr(exposure_trigger_sequencer_pkg::ADDR_OFFSET, 32'(w[7:0]));
    rd(exposure_trigger_sequencer_pkg::ADDR_OFFSET, rv);
    chk(rv, 32'(w[7:0]), "offset readback");
    chk(o_off, w[7:0], "offset output");
    $display("done: registers");
    fork
      u_host.pulse(0, 12);
      begin repeat (9) @(posedge i_clk); #1 chk(o_echo_n, 0, "echo"); end
    join
    fork
      u_host.pulse(1, 12);
      begin repeat (9) @(posedge i_clk); #1 chk(o_echo_n, 1, "aux"); end
    join
    $display("done: echo");
    e = 5 + ($unsigned($random(seed)) % 32);
    one(3, 1, 0, 4, 0);
    chk(n_st, e, "single exposure");
    chk(n_ov, 0, "single no overlap");
    one(3, 0, 1, 4, 0);
    chk(n_st, 0, "strobe off");
    w = 20 + ($unsigned($random(seed)) % 40);
    one(4, 1, 1, w, 1);
    chk(n_st >= w - 1 && n_st <= w + 1, 1, "bulb width");
    $display("done: single and bulb");
    cont(0, 20);
    chk(fr0 >= 3 && ov0 > 0, 1, "overlap run");
    chk(st0 >= 20 && st0 <= 20 * (fr0 + 1), 1, "shutter");
    wr(exposure_trigger_sequencer_pkg::ADDR_CMD, 32'h0000_0001);
    wait_st(exposure_trigger_sequencer_pkg::ST_ARMED);
    wr(exposure_trigger_sequencer_pkg::ADDR_CMD, 32'h0000_0002);
    cont(1, 300);
    chk(st0, 0, "extended strobe");
    chk(fr0 == 2, 1, "extended rate");
    cont(2, 40);
    chk(ov0 == 0 && fr0 >= 2, 1, "non-overlap");
    $display("done: continuous");
    wr(exposure_trigger_sequencer_pkg::ADDR_CTRL, cw(0, 0, 1, 1));
    repeat (3) @(posedge i_clk);
    chk(o_strobe, 1, "gpo high");
    wr(exposure_trigger_sequencer_pkg::ADDR_CTRL, cw(0, 1, 1, 0));
    repeat (3) @(posedge i_clk);
    chk(o_strobe, 0, "gpo low");
    $display("done: general output");
    summarize();
  end
endmodule : exposure_trigger_sequencer_test
`default_nettype wire
